// ==== hdl/mls_monitor.sv ====
/*
 * Monitor-mode host link: security entry, stacking, command sequencer.
 * Assumes a byte memory port whose read data settles within the cycle
 * of the read strobe, and CPU register values stable at monitor entry.
 */
// What this block does
// - NRZ framing, same baud both directions
// - Break is ten low bits
// - Echo every received byte
// - Eleven-bit pause; break cancels command
// - Indexed commands step through memory
// - Entry stacks interrupt frame plus index high
// - Run pulls index high, then returns
// - Stack pointer read returns pointer plus one
// - Stacked PC at pointer plus five, six
// - After power-on, compare eight security bytes
// - All match unlocks flash read and execute
// - Unlock survives all but power-on reset
// - Non-power-on reset skips security bytes
// - Locked flash reads return invalid value
// - Locked flash fetch raises illegal reset
// - Break sent after eight bytes; host break echoed only in ST_CMD and ST_PAUSE
// - Accepted code sets RAM flag bit
// - Mass erase makes security bytes blank
`timescale 1ns/100ps
module mls_monitor
	import mls_pkg::*;
#(
	parameter int BIT_CYC = BIT_CYC_DEF,
	parameter logic [15:0] FLASH_BASE = FLASH_BASE_DEF,
	parameter logic [7:0] INVALID_BYTE = INVALID_DEF
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic por_i,
	// Monitor data pin
	input wire logic mon_pin_i,
	output logic mon_pin_o,
	output logic mon_pin_oe_o,
	// Memory port
	output logic [15:0] mem_addr_o,
	output logic [7:0] mem_wdata_o,
	output logic mem_rd_o,
	output logic mem_wr_o,
	input wire logic [7:0] mem_rdata_i,
	// CPU state at entry
	input wire logic [15:0] sp_i,
	input wire logic [15:0] pc_i,
	input wire logic [7:0] h_i,
	input wire logic [7:0] x_i,
	input wire logic [7:0] a_i,
	input wire logic [7:0] ccr_i,
	// Flash status and fetch guard
	input wire logic flash_blank_i,
	input wire logic fetch_flash_i,
	output logic illegal_rst_o,
	output logic unlocked_o,
	// Resume to user program
	output logic run_o,
	output logic [15:0] run_pc_o,
	output logic [15:0] run_sp_o,
	output logic [7:0] run_h_o,
	output logic [7:0] run_x_o,
	output logic [7:0] run_a_o,
	output logic [7:0] run_ccr_o
);
	localparam logic [15:0] GAP_CYC = 16'(BIT_CYC * ECHO_GAP_BITS);
	localparam logic [15:0] PAUSE_CYC = 16'(BIT_CYC * PAUSE_BITS);

	// Refuse bit times the 16-bit pause timer cannot hold
	if (BIT_CYC < 4 || BIT_CYC * PAUSE_BITS > 65535) begin : g_bit_cyc_chk
		$error("BIT_CYC out of range for the 16-bit bit timer");
	end

	mls_ser_if ser();
	mls_state_t st_r, st_nxt, ret_r, ret_nxt;
	logic [15:0] cnt_r, cnt_nxt, addr_r, addr_nxt, ix_r, ix_nxt, sp_r, sp_nxt;
	logic [15:0] maddr_r, maddr_nxt, pc_r, pc_nxt;
	logic [2:0] idx_r, idx_nxt;
	logic [7:0] op_r, op_nxt, data_r, data_nxt, txd_r, txd_nxt, mwd_r, mwd_nxt;
	logic [7:0] rh_r, rh_nxt, rx_r, rx_nxt, ra_r, ra_nxt, rc_r, rc_nxt;
	logic txb_r, txb_nxt, mrd_r, mrd_nxt, mwr_r, mwr_nxt, run_r, run_nxt;
	logic ill_r, ill_nxt;
	logic cmp_vld, cmp_last, unlocked;
	logic [15:0] sp_inc;

	function automatic logic [2:0] cmd_len(input logic [7:0] op);
		case (op)
			CMD_READ: cmd_len = 3'h3;
			CMD_WRITE: cmd_len = 3'h4;
			CMD_INDEXED_WRITE_CMD: cmd_len = 3'h2;
			default: cmd_len = 3'h1;
		endcase
	endfunction

	function automatic logic [7:0] frame_byte(input logic [2:0] step, input logic [15:0] pc,
			input logic [7:0] x, input logic [7:0] a, input logic [7:0] ccr, input logic [7:0] h);
		case (step)
			3'h0: frame_byte = pc[7:0];
			3'h1: frame_byte = pc[15:8];
			3'h2: frame_byte = x;
			3'h3: frame_byte = a;
			3'h4: frame_byte = ccr;
			default: frame_byte = h;
		endcase
	endfunction

	mls_uart #(
		.BIT_CYC(BIT_CYC)
	) u_uart (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.ser(ser.uart),
		.pin_i(mon_pin_i),
		.pin_o(mon_pin_o),
		.pin_oe_o(mon_pin_oe_o)
	);

	mls_sec_gate u_gate (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.por_i(por_i),
		.cmp_vld_i(cmp_vld),
		.last_i(cmp_last),
		.rx_byte_i(data_r),
		.ref_byte_i(mem_rdata_i),
		.flash_blank_i(flash_blank_i),
		.unlocked_o(unlocked)
	);

	assign sp_inc = sp_r + 16'h0001;
	assign ser.tx_req = (st_r == ST_TX);
	assign ser.tx_brk = txb_r;
	assign ser.tx_data = txd_r;

	always_comb begin
		st_nxt = st_r;
		ret_nxt = ret_r;
		cnt_nxt = (cnt_r != 16'h0000) ? cnt_r - 16'h0001 : cnt_r;
		idx_nxt = idx_r;
		op_nxt = op_r;
		addr_nxt = addr_r;
		ix_nxt = ix_r;
		sp_nxt = sp_r;
		data_nxt = data_r;
		txd_nxt = txd_r;
		txb_nxt = 1'b0;
		maddr_nxt = maddr_r;
		mwd_nxt = mwd_r;
		mrd_nxt = 1'b0;
		mwr_nxt = 1'b0;
		pc_nxt = pc_r;
		rh_nxt = rh_r;
		rx_nxt = rx_r;
		ra_nxt = ra_r;
		rc_nxt = rc_r;
		run_nxt = 1'b0;
		cmp_vld = 1'b0;
		cmp_last = 1'b0;
		ill_nxt = fetch_flash_i && !unlocked;
		case (st_r)
			ST_SECRX: begin
				if (ser.rx_vld) begin
					data_nxt = ser.rx_data;
					maddr_nxt = SEC_BASE + 16'(idx_r);
					mrd_nxt = 1'b1;
					st_nxt = ST_SECCMP;
				end
			end
			ST_SECCMP: begin
				cmp_vld = 1'b1;
				cmp_last = (idx_r == SEC_LAST);
				txd_nxt = data_r;
				ret_nxt = (idx_r == SEC_LAST) ? ST_SECBRK : ST_SECRX;
				idx_nxt = idx_r + 3'h1;
				cnt_nxt = GAP_CYC;
				st_nxt = ST_GAP;
			end
			ST_SECBRK: begin
				txb_nxt = 1'b1;
				ret_nxt = ST_SECFLAG;
				cnt_nxt = GAP_CYC;
				st_nxt = ST_GAP;
			end
			ST_SECFLAG: begin
				if (unlocked) begin
					maddr_nxt = SEC_FLAG_ADDR;
					mwd_nxt = SEC_FLAG_MASK;
					mwr_nxt = 1'b1;
				end
				st_nxt = ST_STACK;
			end
			ST_STACK: begin
				maddr_nxt = sp_r;
				mwd_nxt = frame_byte(idx_r, pc_i, x_i, a_i, ccr_i, h_i);
				mwr_nxt = 1'b1;
				sp_nxt = sp_r - 16'h0001;
				idx_nxt = (idx_r == FRAME_LAST) ? 3'h0 : idx_r + 3'h1;
				if (idx_r == FRAME_LAST)
					st_nxt = ST_CMD;
			end
			ST_CMD: begin
				if (ser.rx_brk) begin
					txb_nxt = 1'b1;
					idx_nxt = 3'h0;
					ret_nxt = ST_CMD;
					cnt_nxt = GAP_CYC;
					st_nxt = ST_GAP;
				end else if (ser.rx_vld) begin
					data_nxt = ser.rx_data;
					if (idx_r == 3'h0)
						op_nxt = ser.rx_data;
					else if (idx_r != 3'h3 && (op_r == CMD_READ || op_r == CMD_WRITE))
						addr_nxt = {addr_r[7:0], ser.rx_data};
					txd_nxt = ser.rx_data;
					ret_nxt = (idx_r + 3'h1 == cmd_len(idx_r == 3'h0 ? ser.rx_data : op_r)) ?
						ST_PAUSE : ST_CMD;
					idx_nxt = idx_r + 3'h1;
					cnt_nxt = GAP_CYC;
					st_nxt = ST_GAP;
				end
			end
			ST_PAUSE: begin
				idx_nxt = 3'h0;
				if (ser.rx_brk) begin
					txb_nxt = 1'b1;
					ret_nxt = ST_CMD;
					cnt_nxt = GAP_CYC;
					st_nxt = ST_GAP;
				end else if (cnt_r == 16'h0000) begin
					st_nxt = ST_EXEC;
				end
			end
			ST_EXEC: begin
				st_nxt = ST_CMD;
				case (op_r)
					CMD_READ: begin
						maddr_nxt = addr_r;
						mrd_nxt = 1'b1;
						ix_nxt = addr_r + 16'h0001;
						st_nxt = ST_RDMEM;
					end
					CMD_INDEXED_READ_CMD: begin
						maddr_nxt = ix_r;
						mrd_nxt = 1'b1;
						ix_nxt = ix_r + 16'h0001;
						st_nxt = ST_RDMEM;
					end
					CMD_WRITE: begin
						maddr_nxt = addr_r;
						mwd_nxt = data_r;
						mwr_nxt = 1'b1;
						ix_nxt = addr_r + 16'h0001;
					end
					CMD_INDEXED_WRITE_CMD: begin
						maddr_nxt = ix_r;
						mwd_nxt = data_r;
						mwr_nxt = 1'b1;
						ix_nxt = ix_r + 16'h0001;
					end
					CMD_READ_STACK_PTR_CMD: begin
						txd_nxt = (idx_r == 3'h0) ? sp_inc[15:8] : sp_inc[7:0];
						ret_nxt = (idx_r == 3'h0) ? ST_EXEC : ST_CMD;
						idx_nxt = (idx_r == 3'h0) ? 3'h1 : 3'h0;
						cnt_nxt = GAP_CYC;
						st_nxt = ST_GAP;
					end
					CMD_RUN: begin
						idx_nxt = 3'h0;
						st_nxt = ST_RUN;
					end
					default: begin
						idx_nxt = 3'h0;
					end
				endcase
			end
			ST_RDMEM: begin
				// Gate on the address just read so the host never sees locked flash
				txd_nxt = (!unlocked && maddr_r >= FLASH_BASE) ? INVALID_BYTE : mem_rdata_i;
				if (op_r == CMD_INDEXED_READ_CMD && idx_r == 3'h0) begin
					idx_nxt = 3'h1;
					ret_nxt = ST_EXEC;
				end else begin
					idx_nxt = 3'h0;
					ret_nxt = ST_CMD;
				end
				cnt_nxt = GAP_CYC;
				st_nxt = ST_GAP;
			end
			ST_RUN: begin
				maddr_nxt = sp_inc;
				mrd_nxt = 1'b1;
				sp_nxt = sp_inc;
				st_nxt = ST_RUNRD;
			end
			ST_RUNRD: begin
				// Frame is reread from memory so host edits take effect
				case (idx_r)
					3'h0: rh_nxt = mem_rdata_i;
					3'h1: rc_nxt = mem_rdata_i;
					3'h2: ra_nxt = mem_rdata_i;
					3'h3: rx_nxt = mem_rdata_i;
					3'h4: pc_nxt = {mem_rdata_i, pc_r[7:0]};
					default: pc_nxt = {pc_r[15:8], mem_rdata_i};
				endcase
				idx_nxt = (idx_r == FRAME_LAST) ? 3'h0 : idx_r + 3'h1;
				if (idx_r == FRAME_LAST) begin
					run_nxt = 1'b1;
					st_nxt = ST_CMD;
				end else begin
					st_nxt = ST_RUN;
				end
			end
			ST_GAP: begin
				txb_nxt = txb_r;
				if (cnt_r == 16'h0000)
					st_nxt = ST_TX;
			end
			ST_TX: begin
				txb_nxt = txb_r;
				st_nxt = ST_TXW;
			end
			ST_TXW: begin
				// The host keeps quiet one bit after each echo, so no overrun guard here
				if (!ser.tx_busy) begin
					cnt_nxt = PAUSE_CYC;
					st_nxt = ret_r;
				end
			end
			default: st_nxt = ST_CMD;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_r <= por_i ? ST_SECRX : ST_STACK;
			ret_r <= ST_CMD;
			cnt_r <= 16'h0000;
			idx_r <= 3'h0;
			op_r <= 8'h00;
			addr_r <= 16'h0000;
			ix_r <= 16'h0000;
			sp_r <= sp_i;
			data_r <= 8'h00;
			txd_r <= 8'h00;
			txb_r <= 1'b0;
			maddr_r <= 16'h0000;
			mwd_r <= 8'h00;
			mrd_r <= 1'b0;
			mwr_r <= 1'b0;
			pc_r <= 16'h0000;
			rh_r <= 8'h00;
			rx_r <= 8'h00;
			ra_r <= 8'h00;
			rc_r <= 8'h00;
			run_r <= 1'b0;
			ill_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			ret_r <= ret_nxt;
			cnt_r <= cnt_nxt;
			idx_r <= idx_nxt;
			op_r <= op_nxt;
			addr_r <= addr_nxt;
			ix_r <= ix_nxt;
			sp_r <= sp_nxt;
			data_r <= data_nxt;
			txd_r <= txd_nxt;
			txb_r <= txb_nxt;
			maddr_r <= maddr_nxt;
			mwd_r <= mwd_nxt;
			mrd_r <= mrd_nxt;
			mwr_r <= mwr_nxt;
			pc_r <= pc_nxt;
			rh_r <= rh_nxt;
			rx_r <= rx_nxt;
			ra_r <= ra_nxt;
			rc_r <= rc_nxt;
			run_r <= run_nxt;
			ill_r <= ill_nxt;
		end
	end

	assign mem_addr_o = maddr_r;
	assign mem_wdata_o = mwd_r;
	assign mem_rd_o = mrd_r;
	assign mem_wr_o = mwr_r;
	assign illegal_rst_o = ill_r;
	assign unlocked_o = unlocked;
	assign run_o = run_r;
	assign run_pc_o = pc_r;
	assign run_sp_o = sp_r;
	assign run_h_o = rh_r;
	assign run_x_o = rx_r;
	assign run_a_o = ra_r;
	assign run_ccr_o = rc_r;
endmodule // mls_monitor

// ==== hdl/mls_pkg.sv ====
/*
 * Shared constants and types of the monitor link security block.
 * Assumes a 20 MHz bus clock and a byte-wide system memory port.
 */
package mls_pkg;

	// Bus clock and default serial rate
	localparam int CLK_HZ = 20_000_000;
	localparam int BAUD_DEF = 9600;
	localparam int BIT_CYC_DEF = CLK_HZ / BAUD_DEF;

	// Spacing in bit times
	localparam int ECHO_GAP_BITS = 2;
	localparam int PAUSE_BITS = 11;

	// Serial framing: start, 8 data, stop; break is 10 low bits plus a high stop
	localparam logic [3:0] BYTE_BITS = 4'ha;
	localparam logic [3:0] BRK_BITS = 4'hb;
	localparam logic [3:0] RX_STOP_IDX = 4'h9;
	localparam logic [3:0] RX_WAIT_IDX = 4'ha;

	// Security gate
	localparam logic [15:0] SEC_BASE = 16'hfff6;
	localparam logic [2:0] SEC_LAST = 3'h7;
	localparam logic [15:0] SEC_FLAG_ADDR = 16'h0040;
	localparam logic [7:0] SEC_FLAG_MASK = 8'h40;
	localparam logic [7:0] ERASED_BYTE = 8'hff;
	localparam logic [7:0] INVALID_DEF = 8'h00;
	localparam logic [15:0] FLASH_BASE_DEF = 16'hc000;

	// Stack frame: five interrupt bytes plus the index high byte
	localparam logic [2:0] FRAME_LAST = 3'h5;

	// Command opcodes
	localparam logic [7:0] CMD_READ = 8'h01;
	localparam logic [7:0] CMD_WRITE = 8'h02;
	localparam logic [7:0] CMD_INDEXED_READ_CMD = 8'h03;
	localparam logic [7:0] CMD_INDEXED_WRITE_CMD = 8'h04;
	localparam logic [7:0] CMD_READ_STACK_PTR_CMD = 8'h05;
	localparam logic [7:0] CMD_RUN = 8'h06;

	typedef enum logic [13:0] {
		ST_SECRX = 14'h0001,
		ST_SECCMP = 14'h0002,
		ST_SECBRK = 14'h0004,
		ST_SECFLAG = 14'h0008,
		ST_STACK = 14'h0010,
		ST_CMD = 14'h0020,
		ST_PAUSE = 14'h0040,
		ST_EXEC = 14'h0080,
		ST_RDMEM = 14'h0100,
		ST_RUN = 14'h0200,
		ST_RUNRD = 14'h0400,
		ST_GAP = 14'h0800,
		ST_TX = 14'h1000,
		ST_TXW = 14'h2000
	} mls_state_t;

endpackage

// ==== hdl/mls_sec_gate.sv ====
/*
 * Security comparator and lock state.
 * Assumes reference bytes are presented one per compare strobe.
 */
`timescale 1ns/100ps
module mls_sec_gate
	import mls_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic por_i,
	// Compare stream
	input wire logic cmp_vld_i,
	input wire logic last_i,
	input wire logic [7:0] rx_byte_i,
	input wire logic [7:0] ref_byte_i,
	input wire logic flash_blank_i,
	// Result
	output logic unlocked_o
);
	logic match_r, match_nxt, unlocked_r, unlocked_nxt;
	logic [7:0] ref_byte;
	logic hit;

	always_comb begin
		ref_byte = flash_blank_i ? ERASED_BYTE : ref_byte_i;
		hit = (rx_byte_i == ref_byte);
		match_nxt = cmp_vld_i ? (match_r & hit) : match_r;
		unlocked_nxt = (cmp_vld_i && last_i) ? (match_r & hit) : unlocked_r;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			match_r <= 1'b1;
			// Only power-on clears the unlock; other resets keep it
			if (por_i)
				unlocked_r <= 1'b0;
		end else begin
			match_r <= match_nxt;
			unlocked_r <= unlocked_nxt;
		end
	end

	assign unlocked_o = unlocked_r;
endmodule // mls_sec_gate

// ==== hdl/mls_ser_if.sv ====
/*
 * Byte-level link between the monitor sequencer and its serial engine.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
interface mls_ser_if;
	logic rx_vld;
	logic rx_brk;
	logic [7:0] rx_data;
	logic tx_req;
	logic tx_brk;
	logic [7:0] tx_data;
	logic tx_busy;

	modport uart (output rx_vld, rx_brk, rx_data, tx_busy, input tx_req, tx_brk, tx_data);
	modport ctl (input rx_vld, rx_brk, rx_data, tx_busy, output tx_req, tx_brk, tx_data);
endinterface

// ==== hdl/mls_uart.sv ====
/*
 * Half-duplex NRZ serial engine on the monitor data pin.
 * Assumes the pin has a pull-up and the host leaves it idle while we send.
 */
`timescale 1ns/100ps
module mls_uart
	import mls_pkg::*;
#(
	parameter int BIT_CYC = BIT_CYC_DEF
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Sequencer side
	mls_ser_if.uart ser,
	// Monitor data pin
	input wire logic pin_i,
	output logic pin_o,
	output logic pin_oe_o
);
	localparam logic [15:0] FULL = 16'(BIT_CYC - 1);
	localparam logic [15:0] HALF = 16'(BIT_CYC / 2);

	logic rx_act_r, rx_act_nxt, rx_vld_r, rx_vld_nxt, rx_brk_r, rx_brk_nxt;
	logic [15:0] rx_cnt_r, rx_cnt_nxt, tx_cnt_r, tx_cnt_nxt;
	logic [3:0] rx_bit_r, rx_bit_nxt, tx_bit_r, tx_bit_nxt;
	logic [7:0] rx_sh_r, rx_sh_nxt;
	logic tx_act_r, tx_act_nxt;
	logic [10:0] tx_sh_r, tx_sh_nxt;

	always_comb begin
		rx_act_nxt = rx_act_r;
		rx_cnt_nxt = rx_cnt_r;
		rx_bit_nxt = rx_bit_r;
		rx_sh_nxt = rx_sh_r;
		rx_vld_nxt = 1'b0;
		rx_brk_nxt = 1'b0;
		tx_act_nxt = tx_act_r;
		tx_cnt_nxt = tx_cnt_r;
		tx_bit_nxt = tx_bit_r;
		tx_sh_nxt = tx_sh_r;
		// Receiver is deaf while we drive, so our own echo is never taken as input
		if (!rx_act_r) begin
			if (!tx_act_r && !pin_i) begin
				rx_act_nxt = 1'b1;
				rx_cnt_nxt = HALF;
				rx_bit_nxt = 4'h0;
			end
		end else if (rx_bit_r == RX_WAIT_IDX) begin
			// A break holds the line low; re-arm only once it is released
			if (pin_i)
				rx_act_nxt = 1'b0;
		end else if (rx_cnt_r != 16'h0000) begin
			rx_cnt_nxt = rx_cnt_r - 16'h0001;
		end else begin
			rx_cnt_nxt = FULL;
			rx_bit_nxt = rx_bit_r + 4'h1;
			if (rx_bit_r == 4'h0 && pin_i) begin
				rx_act_nxt = 1'b0;
			end else if (rx_bit_r == RX_STOP_IDX) begin
				if (pin_i) begin
					rx_vld_nxt = 1'b1;
					rx_act_nxt = 1'b0;
				end else if (rx_sh_r == 8'h00) begin
					rx_brk_nxt = 1'b1;
				end
				if (!pin_i)
					rx_bit_nxt = RX_WAIT_IDX;
			end else if (rx_bit_r != 4'h0) begin
				rx_sh_nxt = {pin_i, rx_sh_r[7:1]};
			end
		end
		if (!tx_act_r) begin
			if (ser.tx_req) begin
				tx_act_nxt = 1'b1;
				tx_cnt_nxt = FULL;
				tx_bit_nxt = ser.tx_brk ? BRK_BITS : BYTE_BITS;
				tx_sh_nxt = ser.tx_brk ? 11'h400 : {2'b11, ser.tx_data, 1'b0};
			end
		end else if (tx_cnt_r != 16'h0000) begin
			tx_cnt_nxt = tx_cnt_r - 16'h0001;
		end else begin
			tx_cnt_nxt = FULL;
			tx_sh_nxt = {1'b1, tx_sh_r[10:1]};
			tx_bit_nxt = tx_bit_r - 4'h1;
			if (tx_bit_r == 4'h1)
				tx_act_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rx_act_r <= 1'b0;
			rx_cnt_r <= 16'h0000;
			rx_bit_r <= 4'h0;
			rx_sh_r <= 8'h00;
			rx_vld_r <= 1'b0;
			rx_brk_r <= 1'b0;
			tx_act_r <= 1'b0;
			tx_cnt_r <= 16'h0000;
			tx_bit_r <= 4'h0;
			tx_sh_r <= 11'h7ff;
		end else begin
			rx_act_r <= rx_act_nxt;
			rx_cnt_r <= rx_cnt_nxt;
			rx_bit_r <= rx_bit_nxt;
			rx_sh_r <= rx_sh_nxt;
			rx_vld_r <= rx_vld_nxt;
			rx_brk_r <= rx_brk_nxt;
			tx_act_r <= tx_act_nxt;
			tx_cnt_r <= tx_cnt_nxt;
			tx_bit_r <= tx_bit_nxt;
			tx_sh_r <= tx_sh_nxt;
		end
	end

	assign ser.rx_vld = rx_vld_r;
	assign ser.rx_brk = rx_brk_r;
	assign ser.rx_data = rx_sh_r;
	assign ser.tx_busy = tx_act_r;
	assign pin_o = tx_sh_r[0];
	assign pin_oe_o = tx_act_r;
endmodule // mls_uart

// ==== verif/mls_host.sv ====
/*
 * Host model on the monitor data pin: frames out, frames in.
 * Assumes the pin has a pull-up; releasing the line means driving 1.
 */
`timescale 1ns/100ps
module mls_host #(
	parameter int BIT_CYC = 8
) (
	// Clock
	input wire logic clk_i,
	// Pin
	input wire logic line_i,
	output logic drv_o
);
	initial drv_o = 1'b1;

	// A break is ten low bits; a byte gets an extra idle bit after stop
	task automatic send(input logic [7:0] b, input bit brk);
		logic [9:0] f;
		f = brk ? 10'h000 : {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			drv_o <= f[i];
			repeat (BIT_CYC) @(posedge clk_i);
		end
		drv_o <= 1'b1;
		repeat (BIT_CYC) @(posedge clk_i);
	endtask

	task automatic recv(output logic [7:0] b, output bit brk, output bit ok);
		logic [8:0] s;
		int n;
		n = 0;
		ok = 1'b0;
		brk = 1'b0;
		b = 8'h00;
		while (line_i !== 1'b0 && n < 60 * BIT_CYC) begin
			@(posedge clk_i);
			n++;
		end
		if (line_i === 1'b0) begin
			repeat (BIT_CYC / 2) @(posedge clk_i);
			for (int i = 0; i < 9; i++) begin
				repeat (BIT_CYC) @(posedge clk_i);
				s[i] = line_i;
			end
			b = s[7:0];
			brk = (s === 9'h000);
			n = 0;
			while (line_i !== 1'b1 && n < 4 * BIT_CYC) begin
				@(posedge clk_i);
				n++;
			end
			ok = (line_i === 1'b1);
			repeat (BIT_CYC) @(posedge clk_i);
		end
	endtask
endmodule // mls_host

// ==== verif/mls_monitor_props.sv ====
/*
 * Port-level checker of the monitor link block.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/100ps
module mls_monitor_props
	import mls_pkg::*;
#(
	parameter int BIT_CYC = BIT_CYC_DEF
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic por_i,
	// Pin and memory strobes
	input wire logic mon_pin_o,
	input wire logic mon_pin_oe_o,
	input wire logic mem_rd_o,
	input wire logic mem_wr_o,
	// Security and resume
	input wire logic [15:0] sp_i,
	input wire logic fetch_flash_i,
	input wire logic illegal_rst_o,
	input wire logic unlocked_o,
	input wire logic run_o,
	input wire logic [15:0] run_sp_o
);
	logic [15:0] low_r;
	logic [15:0] low_nxt;
	logic pre_r;

	// Lock state held from the last cycle before reset was raised
	always_ff @(posedge clk_i) begin
		if (!rst_i)
			pre_r <= unlocked_o;
	end

	// Length of the current low run that we drive ourselves
	always_comb begin
		low_nxt = (!rst_i && mon_pin_oe_o && !mon_pin_o) ? low_r + 16'h0001 : 16'h0000;
	end

	always_ff @(posedge clk_i) begin
		low_r <= low_nxt;
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_idle_after_rst: assert property ($fell(rst_i) |-> !mon_pin_oe_o && mon_pin_o)
		else $error("pin driven right after reset");
	chk_bit_length: assert property (mon_pin_oe_o && mon_pin_o && low_r != 16'h0000 |-> (low_r % BIT_CYC) == 0)
		else $error("low run not a whole number of bits");
	chk_break_len: assert property (mon_pin_oe_o && !mon_pin_o |-> int'(low_r) < 10 * BIT_CYC)
		else $error("low run longer than a break");
	chk_strobe_excl: assert property (!(mem_rd_o && mem_wr_o))
		else $error("read and write strobes together");
	chk_fetch_locked: assert property (fetch_flash_i && !unlocked_o |=> illegal_rst_o)
		else $error("locked fetch without illegal reset");
	chk_fetch_cause: assert property (illegal_rst_o |-> $past(fetch_flash_i) && !$past(unlocked_o))
		else $error("illegal reset without locked fetch");
	chk_unlock_keep: assert property ($fell(rst_i) && !$past(por_i) |-> unlocked_o == pre_r)
		else $error("warm reset changed lock state");
	chk_por_relock: assert property ($fell(rst_i) && $past(por_i) |-> !unlocked_o)
		else $error("power-on reset left device open");
	chk_run_pulse: assert property (run_o |=> !run_o)
		else $error("resume strobe longer than one cycle");
	chk_run_stack: assert property (run_o |-> run_sp_o == sp_i)
		else $error("resume stack pointer wrong");
endmodule // mls_monitor_props

// ==== verif/tb.sv ====
/*
 * Self-checking bench: host model on the pin, byte memory model.
 * Assumes the checker and host model files are compiled first.
 */
`timescale 1ns/100ps
module tb;
	import mls_pkg::*;
	localparam int BC = 8;
	localparam logic [15:0] SP0 = 16'h01f0;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic por_i = 1'b1;
	logic flash_blank_i = 1'b0;
	logic fetch_flash_i = 1'b0;
	logic [7:0] mem_rdata_i = 8'h00;
	logic [15:0] sp_i = SP0;
	logic [15:0] pc_i = 16'h0000;
	logic [7:0] h_i = 8'h00, x_i = 8'h00, a_i = 8'h00, ccr_i = 8'h00;
	logic mon_pin_i, mon_pin_o, mon_pin_oe_o, host_drv;
	logic [15:0] mem_addr_o, run_pc_o, run_sp_o, v;
	logic [7:0] mem_wdata_o, run_h_o, run_x_o, run_a_o, run_ccr_o, r, r2;
	logic mem_rd_o, mem_wr_o, illegal_rst_o, unlocked_o, run_o;
	logic [7:0] mem [0:65535];
	logic [7:0] key [0:7];
	bit brk;
	int n_fail = 0, checked = 0, seed = 4096;

	always #25 clk_i = ~clk_i;
	// Pull-up holds the line high unless someone drives it
	assign mon_pin_i = mon_pin_oe_o ? mon_pin_o : host_drv;

	mls_monitor #(.BIT_CYC(BC)) u_dut (.clk_i, .rst_i, .por_i, .mon_pin_i, .mon_pin_o,
		.mon_pin_oe_o, .mem_addr_o, .mem_wdata_o, .mem_rd_o, .mem_wr_o, .mem_rdata_i, .sp_i,
		.pc_i, .h_i, .x_i, .a_i, .ccr_i, .flash_blank_i, .fetch_flash_i, .illegal_rst_o,
		.unlocked_o, .run_o, .run_pc_o, .run_sp_o, .run_h_o, .run_x_o, .run_a_o, .run_ccr_o);
	mls_host #(.BIT_CYC(BC)) u_host (.clk_i, .line_i(mon_pin_i), .drv_o(host_drv));

	// Writes land at the edge; read data settles mid-cycle while the strobe stands
	always @(posedge clk_i) begin
		if (mem_wr_o === 1'b1) mem[mem_addr_o] <= mem_wdata_o;
	end
	always @(negedge clk_i) begin
		if (mem_rd_o === 1'b1) mem_rdata_i <= mem[mem_addr_o];
	end

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("Checks %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic get(output logic [7:0] b, output bit k);
		bit ok;
		u_host.recv(b, k, ok);
		if (!ok) begin
			n_fail++;
			$display("BAD serial reply expected 1 seen 0");
			test_done();
		end
	endtask

	task automatic tx(input logic [7:0] b);
		logic [7:0] e;
		bit k;
		u_host.send(b, 1'b0);
		get(e, k);
		chk("echo", {7'h00, k, e}, {8'h00, b});
	endtask

	task automatic addr_cmd(input logic [7:0] op, input logic [15:0] a);
		tx(op);
		tx(a[15:8]);
		tx(a[7:0]);
	endtask

	// Writes complete only after the command pause
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		addr_cmd(CMD_WRITE, a);
		tx(d);
		repeat (12 * BC) @(posedge clk_i);
	endtask

	task automatic rd_sp(output logic [15:0] p);
		bit k;
		tx(CMD_READ_STACK_PTR_CMD);
		get(p[15:8], k);
		get(p[7:0], k);
	endtask

	task automatic do_rst(input logic por);
		@(posedge clk_i);
		rst_i <= 1'b1;
		por_i <= por;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
	endtask

	task automatic chk_stack();
		logic [7:0] e [0:5];
		e = '{pc_i[7:0], pc_i[15:8], x_i, a_i, ccr_i, h_i};
		for (int i = 0; i < 6; i++) chk("stack", {8'h00, mem[SP0 - 16'(i)]}, {8'h00, e[i]});
	endtask

	task automatic secure(input logic [7:0] flip, input bit blank, input logic open);
		logic [7:0] b;
		bit k;
		mem[16'h0040] = 8'h00;
		for (int i = 0; i < 8; i++) begin
			b = blank ? ERASED_BYTE : key[i] ^ (i == 7 ? flip : 8'h00);
			tx(b);
		end
		get(b, k);
		chk("ready break", {15'h0000, k}, 16'h0001);
		repeat (12) @(posedge clk_i);
		chk("unlocked", {15'h0000, unlocked_o}, {15'h0000, open});
		chk("flag bit", {15'h0000, mem[16'h0040][6]}, {15'h0000, open});
		chk_stack();
	endtask

	task automatic fetch(input logic exp);
		@(posedge clk_i);
		fetch_flash_i <= 1'b1;
		@(posedge clk_i);
		fetch_flash_i <= 1'b0;
		@(negedge clk_i);
		chk("illegal reset", {15'h0000, illegal_rst_o}, {15'h0000, exp});
	endtask

	initial begin
		for (int i = 0; i < 65536; i++) mem[i] = 8'(i ^ (i >> 8));
		for (int i = 0; i < 8; i++) key[i] = 8'($random(seed));
		for (int i = 0; i < 8; i++) mem[SEC_BASE + 16'(i)] = key[i];
		@(posedge clk_i);
		pc_i <= 16'($random(seed));
		h_i <= 8'($random(seed));
		x_i <= 8'($random(seed));
		a_i <= 8'($random(seed));
		ccr_i <= 8'($random(seed));
		do_rst(1'b1);
		secure(8'h00, 1'b0, 1'b1);
		rd_sp(v);
		chk("stack pointer", v, SP0 - 16'h0005);
		addr_cmd(CMD_READ, 16'hfffc);
		get(r, brk);
		chk("read", {8'h00, r}, {8'h00, mem[16'hfffc]});
		for (int i = 0; i < 4; i++) begin
			if (i % 2 == 0) tx(CMD_INDEXED_READ_CMD);
			get(r, brk);
			chk("indexed read", {8'h00, r}, {8'h00, mem[16'hfffd + 16'(i)]});
		end
		r = 8'($random(seed));
		r2 = 8'($random(seed));
		wr(16'h0080, r);
		tx(CMD_INDEXED_WRITE_CMD);
		tx(r2);
		repeat (12 * BC) @(posedge clk_i);
		chk("write", {mem[16'h0080], mem[16'h0081]}, {r, r2});
		tx(CMD_READ_STACK_PTR_CMD);
		u_host.send(8'h00, 1'b1);
		get(r, brk);
		chk("cancel break", {15'h0000, brk}, 16'h0001);
		rd_sp(v);
		chk("stack pointer", v, SP0 - 16'h0005);
		u_host.send(8'h00, 1'b1);
		get(r, brk);
		chk("idle break", {15'h0000, brk}, 16'h0001);
		v = 16'($random(seed));
		wr(SP0 - 16'h0001, v[15:8]);
		wr(SP0, v[7:0]);
		tx(CMD_RUN);
		for (int n = 0; n < 30 * BC && run_o !== 1'b1; n++) @(negedge clk_i);
		chk("run strobe", {15'h0000, run_o}, 16'h0001);
		chk("run pc", run_pc_o, v);
		chk("run sp", run_sp_o, SP0);
		chk("run regs", {run_x_o, run_a_o}, {x_i, a_i});
		chk("run h ccr", {run_h_o, run_ccr_o}, {h_i, ccr_i});
		fetch(1'b0);
		do_rst(1'b0);
		rd_sp(v);
		chk("warm stack pointer", v, SP0 - 16'h0005);
		chk("warm unlocked", {15'h0000, unlocked_o}, 16'h0001);
		chk_stack();
		do_rst(1'b1);
		secure(8'h5a, 1'b0, 1'b0);
		addr_cmd(CMD_READ, SEC_BASE);
		get(r, brk);
		chk("locked read", {8'h00, r}, {8'h00, INVALID_DEF});
		addr_cmd(CMD_READ, 16'h0080);
		get(r, brk);
		chk("ram read", {8'h00, r}, {8'h00, mem[16'h0080]});
		fetch(1'b1);
		flash_blank_i <= 1'b1;
		do_rst(1'b1);
		secure(8'h00, 1'b1, 1'b1);
		test_done();
	end
endmodule // tb

bind mls_monitor mls_monitor_props #(.BIT_CYC(BIT_CYC)) u_props (.clk_i, .rst_i, .por_i,
	.mon_pin_o, .mon_pin_oe_o, .mem_rd_o, .mem_wr_o, .sp_i, .fetch_flash_i, .illegal_rst_o,
	.unlocked_o, .run_o, .run_sp_o);
